// ==== verilog/aea_top.sv ====
// per-port list entry store with indirect host access and action decode
`timescale 1ns/10ps
`default_nettype none
`include "aea_defines.svh"
// Notes on behaviour
// - priority mode keeps, raises-only, lowers-only or replaces the classified priority
// - entry priority sits in bits 5-3 of action byte 10
// - remark enable bit 2 of byte 10 makes priority bits be rewritten
// - remark value is bits 1-0 of byte 10 above bit 7 of byte 11
// - map mode ignores, ORs, ANDs or substitutes the entry port map
// - entry port map bits 4-0 of byte 11, bit 0 is port 1
// - counter use: port map bit 4 picks microsecond or millisecond unit
// - bit 3 clear: count down from action value, interrupt on expiry
// - bit 3 set: count matched packets up to action value, then interrupt
// - sixteen-bit rule set mask at offsets 0x0c high and 0x0d low
// - table select 0x6e, offset 0x6f and data 0xa0 reach the entries
// - writing control byte 0x12 starts read or write of entries 0 to 15
// - control bits 6 and 5 show write and read done, both set after reset
// - bit 0 at 0x13 forces ring redundancy packets to single-entry miss
// - byte enables at 0x10 and 0x11 choose bytes taking part in a transfer
// - entry byte reads return holding bytes only where byte enable is set
module aea_top
   import aea_pkg::*;
#(
   parameter int PORTS = 5,
   parameter int ENTRIES = 16,
   parameter int ENTRY_BYTES = 14
) (
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata_q,
   input wire logic match_valid,
   input wire logic [3:0] match_port,
   input wire logic [3:0] match_entry,
   input wire logic [1:0] match_mode,
   input wire logic [1:0] match_enable,
   input wire logic [2:0] qos_prio,
   input wire logic [4:0] lut_map,
   output logic match_ready_q,
   output aea_result_t result_q,
   output logic count_irq_q,
   output logic [15:0] cascade_rule_mask_q,
   output logic [4:0] ring_redundancy_q
);
   localparam int AW = 7;
   localparam int WIDTH = ENTRY_BYTES * 8;

   aea_top_st_t st_q, st_d;
   aea_top_st_t st_rst;
   logic [AW-1:0] mem_addr;
   logic mem_we;
   logic [WIDTH-1:0] mem_rdata;
   logic [WIDTH-1:0] merged;
   logic [ENTRY_BYTES-1:0][7:0] loaded;
   logic [3:0] nib;
   logic sel_ok;
   logic data_wr;
   logic data_rd;
   logic start;
   logic [2:0] sel_idx;
   logic [3:0] ofs_idx;
   logic [ENTRY_BYTES-1:0] be_rev;
   logic ofs_entry;
   logic [7:0] ctrl_byte;
   logic [7:0] rd_byte;

   // reset image of the state
   always_comb begin
      st_rst = '0;
      st_rst.state = ST_IDLE;
      st_rst.tbl_sel = `AEA_TBL_SEL_RST;
      st_rst.byte_en = `AEA_BE_RST;
      st_rst.wr_done = 1'b1;
      st_rst.rd_done = 1'b1;
      st_rst.match_ready = 1'b1;
   end

   // table and port decode of the indirect selection
   assign nib = st_q.tbl_sel[3:0];
   assign sel_ok = (st_q.tbl_sel[7:5] == `AEA_TBL_ACL) && (nib >= `AEA_PORT_FIRST)
                   && (nib <= `AEA_PORT_LAST);
   assign sel_idx = 3'(nib - `AEA_PORT_FIRST);
   assign data_wr = reg_wr && (reg_addr == `AEA_DATA_ADDR) && sel_ok;
   assign data_rd = reg_rd && (reg_addr == `AEA_DATA_ADDR) && sel_ok;
   assign start = data_wr && (st_q.offset == `AEA_OFS_CTRL) && (st_q.state == ST_IDLE);
   assign ofs_entry = (st_q.offset <= `AEA_OFS_LAST_BYTE);
   assign ofs_idx = st_q.offset[3:0];
   assign ctrl_byte = {1'b0, st_q.wr_done, st_q.rd_done, st_q.op_write, st_q.entry};

   // per-byte merge for writes and holding-buffer load for reads
   generate
      for (genvar g = 0; g < ENTRY_BYTES; g++) begin : g_byte
         // enable word holds byte 0 in its top bit and byte 13 in bit 0
         assign be_rev[g] = st_q.byte_en[ENTRY_BYTES-1-g];
         assign merged[g*8 +: 8] = be_rev[g] ? st_q.hold[g] : mem_rdata[g*8 +: 8];
         assign loaded[g] = be_rev[g] ? mem_rdata[g*8 +: 8] : st_q.hold[g];
      end
   endgenerate

   // value returned for an indirect data read
   always_comb begin
      rd_byte = 8'h00;
      if (ofs_entry) begin
         rd_byte = be_rev[ofs_idx] ? st_q.hold[ofs_idx] : 8'h00;
      end else if (st_q.offset == `AEA_OFS_BE_HI) begin
         rd_byte = {2'h0, st_q.byte_en[13:8]};
      end else if (st_q.offset == `AEA_OFS_BE_LO) begin
         rd_byte = st_q.byte_en[7:0];
      end else if (st_q.offset == `AEA_OFS_CTRL) begin
         rd_byte = ctrl_byte;
      end else if (st_q.offset == `AEA_OFS_RING) begin
         rd_byte = {7'h00, st_q.ring[sel_idx]};
      end
   end

   // host access, transfer sequencing and match lookup
   always_comb begin
      st_d = st_q;
      mem_we = 1'b0;
      mem_addr = {st_q.port_idx, st_q.entry};
      // direct register writes
      if (reg_wr) begin
         if (reg_addr == `AEA_TBL_SEL_ADDR) begin
            st_d.tbl_sel = reg_wdata;
         end else if (reg_addr == `AEA_OFFSET_ADDR) begin
            st_d.offset = reg_wdata;
         end
      end
      // indirect data writes
      if (data_wr) begin
         if (ofs_entry) begin
            st_d.hold[ofs_idx] = reg_wdata;
         end else if (st_q.offset == `AEA_OFS_BE_HI) begin
            st_d.byte_en[13:8] = reg_wdata[5:0];
         end else if (st_q.offset == `AEA_OFS_BE_LO) begin
            st_d.byte_en[7:0] = reg_wdata;
         end else if (st_q.offset == `AEA_OFS_RING) begin
            st_d.ring[sel_idx] = reg_wdata[0];
         end
      end
      // burst: step to the next entry byte after each data access at an offset below 0x0d
      if ((data_wr || data_rd) && (st_q.offset < `AEA_OFS_LAST_BYTE)) begin
         st_d.offset = st_q.offset + 8'h01;
      end
      // register read data
      if (reg_rd) begin
         if (reg_addr == `AEA_TBL_SEL_ADDR) begin
            st_d.rdata = st_q.tbl_sel;
         end else if (reg_addr == `AEA_OFFSET_ADDR) begin
            st_d.rdata = st_q.offset;
         end else if (data_rd) begin
            st_d.rdata = rd_byte;
         end else begin
            st_d.rdata = 8'h00;
         end
      end
      case (st_q.state)
         ST_IDLE: begin
            if (start) begin
               st_d.op_write = reg_wdata[`AEA_CTRL_OP];
               st_d.entry = reg_wdata[3:0];
               st_d.port_idx = sel_idx;
               mem_addr = {sel_idx, reg_wdata[3:0]};
               if (reg_wdata[`AEA_CTRL_OP]) begin
                  st_d.wr_done = 1'b0;
               end else begin
                  st_d.rd_done = 1'b0;
               end
               st_d.state = ST_XFER;
            end else if (match_valid && (match_port >= `AEA_PORT_FIRST)
                         && (match_port <= `AEA_PORT_LAST)) begin
               st_d.m.port_idx = 3'(match_port - `AEA_PORT_FIRST);
               st_d.m.entry = match_entry;
               st_d.m.cnt_use = (match_mode == 2'h1) && (match_enable == 2'h0);
               st_d.m.qos_prio = qos_prio;
               st_d.m.lut_map = lut_map;
               mem_addr = {st_d.m.port_idx, match_entry};
               st_d.state = ST_MATCH;
            end
         end
         ST_XFER: begin
            // stored entry is on mem_rdata now
            if (st_q.op_write) begin
               mem_we = 1'b1;
               st_d.wr_done = 1'b1;
            end else begin
               st_d.hold = loaded;
               st_d.rd_done = 1'b1;
            end
            st_d.state = ST_IDLE;
         end
         ST_MATCH: begin
            mem_addr = {st_q.m.port_idx, st_q.m.entry};
            st_d.state = ST_IDLE;
         end
         default: begin
            st_d.state = ST_IDLE;
         end
      endcase
      st_d.match_ready = (st_d.state == ST_IDLE) && !start;
   end

   // state register
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         st_q <= st_rst;
      end else begin
         st_q <= st_d;
      end
   end

   // entry storage, one row per port and entry
   aea_entry_mem #(
      .DEPTH(PORTS * ENTRIES),
      .AW(AW),
      .WIDTH(WIDTH)
   ) u_mem (
      .clk_sys(clk_sys),
      .addr(mem_addr),
      .we(mem_we),
      .wdata(merged),
      .rdata_q(mem_rdata)
   );

   // action decode on the looked-up entry
   aea_action u_act (
      .clk_sys(clk_sys),
      .reset(reset),
      .valid(st_q.state == ST_MATCH),
      .act_a(mem_rdata[8*`AEA_OFS_PRIO_ACT +: 8]),
      .act_b(mem_rdata[8*`AEA_OFS_FWD_ACT +: 8]),
      .cnt_use(st_q.m.cnt_use),
      .qos_prio(st_q.m.qos_prio),
      .lut_map(st_q.m.lut_map),
      .result_q(result_q),
      .count_irq_q(count_irq_q)
   );

   // holding-buffer rule set mask, high byte first
   assign cascade_rule_mask_q = {st_q.hold[`AEA_OFS_MASK_HI], st_q.hold[`AEA_OFS_MASK_LO]};
   assign ring_redundancy_q = st_q.ring;
   assign reg_rdata_q = st_q.rdata;
   assign match_ready_q = st_q.match_ready;
endmodule
`default_nettype wire

// ==== verilog/aea_defines.svh ====
// register offsets, field positions, reset values and timing counts
`ifndef AEA_DEFINES_SVH
`define AEA_DEFINES_SVH
// direct registers of the host port
`define AEA_TBL_SEL_ADDR 8'h6e
`define AEA_OFFSET_ADDR 8'h6f
`define AEA_DATA_ADDR 8'ha0
`define AEA_TBL_ACL 3'h2
`define AEA_PORT_FIRST 4'h1
`define AEA_PORT_LAST 4'h5
// indirect offsets inside one port's list space
`define AEA_OFS_PRIO_ACT 8'h0a
`define AEA_OFS_FWD_ACT 8'h0b
`define AEA_OFS_MASK_HI 8'h0c
`define AEA_OFS_MASK_LO 8'h0d
`define AEA_OFS_LAST_BYTE 8'h0d
`define AEA_OFS_BE_HI 8'h10
`define AEA_OFS_BE_LO 8'h11
`define AEA_OFS_CTRL 8'h12
`define AEA_OFS_RING 8'h13
// control byte fields
`define AEA_CTRL_WR_DONE 6
`define AEA_CTRL_RD_DONE 5
`define AEA_CTRL_OP 4
// action byte fields
`define AEA_FWD_UNIT_BIT 4
`define AEA_FWD_DIR_BIT 3
// reset values
`define AEA_BE_RST 14'h3fff
`define AEA_TBL_SEL_RST 8'h00
// timing: one microsecond tick at a 40 ns clock
`define AEA_CLK_PERIOD_NS 40
`define AEA_TICK_NS 1000
`define AEA_TICK_CYCLES (`AEA_TICK_NS / `AEA_CLK_PERIOD_NS)
`define AEA_MS_US 1000
`endif

// ==== verilog/aea_pkg.sv ====
// types shared by the list entry access logic
`default_nettype none
package aea_pkg;
   typedef enum logic [1:0] {
      AEA_PRIO_KEEP = 2'h0,
      AEA_PRIO_HIGHER = 2'h1,
      AEA_PRIO_LOWER = 2'h2,
      AEA_PRIO_REPLACE = 2'h3
   } aea_prio_mode_t;
   typedef enum logic [1:0] {
      AEA_MAP_LUT = 2'h0,
      AEA_MAP_OR = 2'h1,
      AEA_MAP_AND = 2'h2,
      AEA_MAP_ENTRY = 2'h3
   } aea_map_mode_t;
   typedef enum logic [1:0] {ST_IDLE, ST_XFER, ST_MATCH} aea_state_t;
   // match request from the classifier
   typedef struct packed {
      logic [2:0] port_idx;
      logic [3:0] entry;
      logic cnt_use;
      logic [2:0] qos_prio;
      logic [4:0] lut_map;
   } aea_match_t;
   // decision handed back to the forwarding path
   typedef struct packed {
      logic valid;
      logic [2:0] prio;
      logic remark_enable;
      logic [2:0] remark_value;
      logic [4:0] fwd_map;
   } aea_result_t;
   typedef struct packed {
      aea_state_t state;
      logic [7:0] tbl_sel;
      logic [7:0] offset;
      logic [13:0][7:0] hold;
      logic [13:0] byte_en;
      logic op_write;
      logic [3:0] entry;
      logic [2:0] port_idx;
      logic wr_done;
      logic rd_done;
      logic [4:0] ring;
      logic [7:0] rdata;
      logic match_ready;
      aea_match_t m;
   } aea_top_st_t;
endpackage
`default_nettype wire

// ==== verilog/aea_entry_mem.sv ====
// entry storage with registered read data
`timescale 1ns/10ps
`default_nettype none
module aea_entry_mem
   import aea_pkg::*;
#(
   parameter int DEPTH = 80,
   parameter int AW = 7,
   parameter int WIDTH = 112
) (
   input wire logic clk_sys,
   input wire logic [AW-1:0] addr,
   input wire logic we,
   input wire logic [WIDTH-1:0] wdata,
   output logic [WIDTH-1:0] rdata_q
);
   logic [WIDTH-1:0] mem [DEPTH];

   // write through the same address, read comes out one edge later
   always_ff @(posedge clk_sys) begin
      if (we && (int'(addr) < DEPTH)) begin
         mem[addr] <= wdata;
      end
      rdata_q <= (int'(addr) < DEPTH) ? mem[addr] : '0;
   end
endmodule
`default_nettype wire

// ==== verilog/aea_action.sv ====
// action field decode and the 11-bit event counter
`timescale 1ns/10ps
`default_nettype none
`include "aea_defines.svh"
module aea_action
   import aea_pkg::*;
#(
   parameter int TICK_CYCLES = `AEA_TICK_CYCLES,
   parameter int MS_US = `AEA_MS_US
) (
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic valid,
   input wire logic [7:0] act_a,
   input wire logic [7:0] act_b,
   input wire logic cnt_use,
   input wire logic [2:0] qos_prio,
   input wire logic [4:0] lut_map,
   output aea_result_t result_q,
   output logic count_irq_q
);
   typedef struct packed {
      aea_result_t res;
      logic irq;
      logic [10:0] cnt;
      logic [10:0] limit;
      logic run;
      logic down;
      logic unit_ms;
      logic [15:0] tick_cnt;
      logic [15:0] us_cnt;
   } aea_act_st_t;
   aea_act_st_t st_q, st_d;
   logic [2:0] entry_prio;
   logic [10:0] cnt_inc;
   logic us_tick, ms_tick, unit_tick;

   assign entry_prio = act_a[5:3];
   assign cnt_inc = st_q.cnt + 11'h001;
   assign us_tick = (st_q.tick_cnt == 16'(TICK_CYCLES - 1));
   assign ms_tick = us_tick && (st_q.us_cnt == 16'(MS_US - 1));
   assign unit_tick = st_q.unit_ms ? ms_tick : us_tick;

   // decision, time base and counter
   always_comb begin
      st_d = st_q;
      st_d.res.valid = 1'b0;
      st_d.irq = 1'b0;
      st_d.tick_cnt = us_tick ? 16'h0000 : st_q.tick_cnt + 16'h0001;
      if (us_tick) begin
         st_d.us_cnt = ms_tick ? 16'h0000 : st_q.us_cnt + 16'h0001;
      end
      // count-down expiry
      if (st_q.run && st_q.down && unit_tick) begin
         if (st_q.cnt <= 11'h001) begin
            st_d.irq = 1'b1;
            st_d.run = 1'b0;
            st_d.cnt = 11'h000;
         end else begin
            st_d.cnt = st_q.cnt - 11'h001;
         end
      end
      if (valid && cnt_use) begin
         if (!act_b[`AEA_FWD_DIR_BIT]) begin
            st_d.cnt = {act_a, act_b[7:5]};
            st_d.run = 1'b1;
            st_d.down = 1'b1;
            st_d.unit_ms = act_b[`AEA_FWD_UNIT_BIT];
         end else begin
            st_d.limit = {act_a, act_b[7:5]};
            st_d.down = 1'b0;
            st_d.cnt = (st_q.run && !st_q.down) ? cnt_inc : 11'h001;
            st_d.run = 1'b1;
            if (st_d.cnt == st_d.limit) begin
               st_d.irq = 1'b1;
               st_d.run = 1'b0;
               st_d.cnt = 11'h000;
            end
         end
      end else if (valid) begin
         st_d.res.valid = 1'b1;
         case (aea_prio_mode_t'(act_a[7:6]))
            AEA_PRIO_HIGHER: st_d.res.prio = (entry_prio > qos_prio) ? entry_prio : qos_prio;
            AEA_PRIO_LOWER: st_d.res.prio = (entry_prio < qos_prio) ? entry_prio : qos_prio;
            AEA_PRIO_REPLACE: st_d.res.prio = entry_prio;
            default: st_d.res.prio = qos_prio;
         endcase
         st_d.res.remark_enable = act_a[2];
         st_d.res.remark_value = {act_a[1:0], act_b[7]};
         case (aea_map_mode_t'(act_b[6:5]))
            AEA_MAP_OR: st_d.res.fwd_map = lut_map | act_b[4:0];
            AEA_MAP_AND: st_d.res.fwd_map = lut_map & act_b[4:0];
            AEA_MAP_ENTRY: st_d.res.fwd_map = act_b[4:0];
            default: st_d.res.fwd_map = lut_map;
         endcase
      end
   end

   // state register
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign result_q = st_q.res;
   assign count_irq_q = st_q.irq;
endmodule
`default_nettype wire

// ==== test/aea_top_sva.sv ====
// port assertions for the entry access block
`timescale 1ns/10ps
`default_nettype none
module aea_top_sva
   import aea_pkg::*;
(
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata_q,
   input wire logic match_valid,
   input wire logic [3:0] match_port,
   input wire logic [1:0] match_mode,
   input wire logic [1:0] match_enable,
   input wire logic match_ready_q,
   input wire aea_result_t result_q,
   input wire logic count_irq_q,
   input wire logic [4:0] ring_redundancy_q
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (reset);
   // match path handshake and result timing
   ready_after_take_a: assert property (match_valid && match_ready_q && !reg_wr &&
      match_port inside {[1:5]} |=> !match_ready_q) else $error("ready high after take");
   result_pulse_a: assert property (result_q.valid |=> !result_q.valid)
      else $error("result valid longer than one cycle");
   result_latency_a: assert property (result_q.valid |->
      $past(match_valid, 2) && $past(match_ready_q, 2)) else $error("result without take");
   irq_pulse_a: assert property (count_irq_q |=> !count_irq_q)
      else $error("counter event longer than one cycle");
   count_no_result_a: assert property (match_valid && match_ready_q && !reg_wr &&
      match_mode == 2'h1 && match_enable == 2'h0 && match_port inside {[1:5]}
      |-> ##2 !result_q.valid) else $error("counter match gave a result");
   // register port read and write behaviour
   unmapped_zero_a: assert property (reg_rd && !(reg_addr inside {8'h6e, 8'h6f, 8'ha0})
      |=> reg_rdata_q == 8'h00) else $error("unmapped read not zero");
   rdata_hold_a: assert property (!reg_rd |=> $stable(reg_rdata_q))
      else $error("read data moved without a read");
   select_readback_a: assert property (reg_wr && reg_addr == 8'h6e ##2
      reg_rd && reg_addr == 8'h6e |=> reg_rdata_q == $past(reg_wdata, 3))
      else $error("table select readback wrong");
   ring_write_only_a: assert property ($changed(ring_redundancy_q) |-> $past(reg_wr))
      else $error("force-miss bits moved without a write");
endmodule
bind aea_top aea_top_sva i_sva (.clk_sys, .reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
   .reg_rdata_q, .match_valid, .match_port, .match_mode, .match_enable, .match_ready_q,
   .result_q, .count_irq_q,
   .ring_redundancy_q);
`default_nettype wire

// ==== test/aea_host_model.sv ====
// host side model driving the indirect register port
`timescale 1ns/10ps
`default_nettype none
module aea_host_model (
   input wire logic clk_sys,
   output logic [7:0] reg_addr,
   output logic [7:0] reg_wdata,
   output logic reg_wr,
   output logic reg_rd,
   input wire logic [7:0] reg_rdata_q
);
   initial begin
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
   end
   // one strobed cycle, lines scrambled once released
   task automatic cyc(input logic [7:0] a, input logic [7:0] d, input logic w);
      @(negedge clk_sys);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = w;
      reg_rd = !w;
      @(negedge clk_sys);
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = ~a;
      reg_wdata = ~d;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      cyc(a, d, 1'b1);
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      cyc(a, 8'h00, 1'b0);
      d = reg_rdata_q;
   endtask
   // table select: list table, read or write, port 1..5
   task automatic sel(input logic [3:0] p, input logic r);
      wr(8'h6e, {3'h2, r, p});
   endtask
   // burst write of list bytes from an offset
   task automatic put(input logic [3:0] p, input logic [7:0] o, input logic [7:0] b[$]);
      sel(p, 1'b0);
      wr(8'h6f, o);
      foreach (b[i]) wr(8'ha0, b[i]);
   endtask
   // one byte fetched by offset write then data read
   task automatic get(input logic [3:0] p, input logic [7:0] o, output logic [7:0] d);
      sel(p, 1'b1);
      wr(8'h6f, o);
      rd(8'ha0, d);
   endtask
   // start a transfer and poll its done bit
   task automatic xfer(input logic [3:0] p, input logic [7:0] c, output logic ok);
      logic [7:0] s;
      put(p, 8'h12, '{c});
      sel(p, 1'b1);
      wr(8'h6f, 8'h12);
      ok = 1'b0;
      for (int i = 0; i < 20 && !ok; i++) begin
         rd(8'ha0, s);
         ok = c[4] ? s[6] : s[5];
      end
   endtask
endmodule
`default_nettype wire

// ==== test/aea_top_bench.sv ====
// self-checking bench for the entry access block
`timescale 1ns/10ps
`default_nettype none
module aea_top_bench
   import aea_pkg::*;
;
   logic clk_sys, reset, reg_wr, reg_rd, match_valid, match_ready_q, count_irq_q;
   logic [7:0] reg_addr, reg_wdata, reg_rdata_q;
   logic [3:0] match_port, match_entry;
   logic [1:0] match_mode, match_enable;
   logic [2:0] qos_prio;
   logic [4:0] lut_map, ring_redundancy_q;
   logic [15:0] cascade_rule_mask_q;
   aea_result_t result_q;
   int errors, check_count;
   aea_top i_dut (.clk_sys, .reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata_q,
      .match_valid, .match_port, .match_entry, .match_mode, .match_enable, .qos_prio,
      .lut_map, .match_ready_q, .result_q, .count_irq_q, .cascade_rule_mask_q,
      .ring_redundancy_q);
   aea_host_model i_host (.clk_sys, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata_q);
   initial begin
      clk_sys = 1'b0;
      forever #20 clk_sys = ~clk_sys;
   end
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      check_count++;
      if (got !== exp) begin
         $display("ERROR %s expected %h seen %h", what, exp, got);
         errors++;
      end
   endtask
   task automatic finish_test();
      $display("checks %0d errors %0d", check_count, errors);
      if (errors == 0 && check_count > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   function automatic logic [2:0] pexp(input logic [1:0] m, input logic [2:0] e,
                                       input logic [2:0] q);
      case (m)
         2'h0: return q;
         2'h1: return (e > q) ? e : q;
         2'h2: return (e < q) ? e : q;
         default: return e;
      endcase
   endfunction
   // one match request, then watch four cycles for its outcome
   task automatic match(input logic [3:0] e, input logic [1:0] mode_sel, input logic [2:0] q,
                        output aea_result_t r, output logic irq);
      @(negedge clk_sys);
      match_entry = e;
      match_mode = mode_sel;
      qos_prio = q;
      match_valid = 1'b1;
      @(negedge clk_sys);
      match_valid = 1'b0;
      r = '0;
      irq = 1'b0;
      for (int i = 0; i < 4; i++) begin
         @(negedge clk_sys);
         if (result_q.valid === 1'b1) r = result_q;
         if (count_irq_q === 1'b1) irq = 1'b1;
      end
   endtask
   task automatic t_reset();
      logic [7:0] v;
      chk("mask", 16'h0000, cascade_rule_mask_q);
      chk("ring", 16'h0000, 16'(ring_redundancy_q));
      i_host.get(4'h1, 8'h12, v);
      chk("ctrl", 16'h0060, 16'(v));
   endtask
   // write an entry, read it back whole and with part of the bytes enabled
   task automatic t_entry();
      logic [7:0] b[$], z[$], v;
      logic ok;
      for (int i = 0; i < 14; i++) begin
         b.push_back(8'(i * 19 + 7));
         z.push_back(8'h00);
      end
      i_host.put(4'h5, 8'h00, b);
      i_host.xfer(4'h5, 8'h1f, ok);
      chk("write done", 16'h1, 16'(ok));
      i_host.put(4'h5, 8'h00, z);
      i_host.xfer(4'h5, 8'h0f, ok);
      chk("read done", 16'h1, 16'(ok));
      chk("mask", {b[12], b[13]}, cascade_rule_mask_q);
      for (int i = 0; i < 14; i++) begin
         i_host.get(4'h5, 8'(i), v);
         chk("entry byte", 16'(b[i]), 16'(v));
      end
      i_host.put(4'h5, 8'h10, '{8'h3f});
      i_host.put(4'h5, 8'h11, '{8'h00});
      for (int i = 4; i < 8; i++) begin
         i_host.get(4'h5, 8'(i), v);
         chk("enabled byte", (i < 6) ? 16'(b[i]) : 16'h0, 16'(v));
      end
      i_host.put(4'h5, 8'h10, '{8'h3f});
      i_host.put(4'h5, 8'h11, '{8'hff});
   endtask
   // every priority and map mode, two classified priorities each
   task automatic t_modes();
      logic [1:0] m;
      logic [4:0] mexp [4] = '{5'h0c, 5'h0d, 5'h04, 5'h05};
      aea_result_t r;
      logic ok, irq;
      for (int i = 0; i < 4; i++) begin
         m = 2'(i);
         i_host.put(4'h5, 8'h0a, '{{m, 3'h5, m[0], 2'h2}, {1'b1, m, 5'h05}});
         i_host.xfer(4'h5, {4'h1, 2'h0, m}, ok);
         chk("write done", 16'h1, 16'(ok));
         for (int q = 3; q < 7; q += 3) begin
            match(4'(i), 2'h0, 3'(q), r, irq);
            chk("valid", 16'h1, 16'(r.valid));
            chk("prio", 16'(pexp(m, 3'h5, 3'(q))), 16'(r.prio));
            chk("remark en", 16'(m[0]), 16'(r.remark_enable));
            if (m[0]) chk("remark", 16'h5, 16'(r.remark_value));
            chk("fwd map", 16'(mexp[i]), 16'(r.fwd_map));
         end
      end
   endtask
   // counting up to two matches, then counting down in microseconds
   task automatic t_count();
      aea_result_t r;
      logic ok, irq;
      int n;
      i_host.put(4'h5, 8'h0a, '{8'h00, 8'h48});
      i_host.xfer(4'h5, 8'h14, ok);
      chk("write done", 16'h1, 16'(ok));
      match(4'h4, 2'h1, 3'h0, r, irq);
      chk("up first", 16'h0, 16'({r.valid, irq}));
      match(4'h4, 2'h1, 3'h0, r, irq);
      chk("up second", 16'h1, 16'({r.valid, irq}));
      i_host.put(4'h5, 8'h0a, '{8'h00, 8'h60});
      i_host.xfer(4'h5, 8'h15, ok);
      chk("write done", 16'h1, 16'(ok));
      match(4'h5, 2'h1, 3'h0, r, irq);
      n = 0;
      while (count_irq_q !== 1'b1 && n < 200) begin
         @(negedge clk_sys);
         n++;
      end
      chk("down expiry", 16'h1, 16'(n >= 45 && n <= 75));
   endtask
   // force-miss bit, select readback and refused accesses
   task automatic t_ring();
      logic [7:0] v;
      i_host.put(4'h3, 8'h13, '{8'h01});
      chk("ring", 16'h0004, 16'(ring_redundancy_q));
      i_host.get(4'h3, 8'h13, v);
      chk("ring byte", 16'h0001, 16'(v));
      i_host.wr(8'h6e, 8'h31);
      i_host.rd(8'h6e, v);
      chk("select", 16'h0031, 16'(v));
      i_host.rd(8'ha0, v);
      chk("bad table", 16'h0000, 16'(v));
      i_host.rd(8'h00, v);
      chk("unmapped", 16'h0000, 16'(v));
   endtask
   initial begin
      errors = 0;
      check_count = 0;
      reset = 1'b1;
      match_valid = 1'b0;
      match_port = 4'h5;
      match_entry = 4'h0;
      match_mode = 2'h0;
      match_enable = 2'h0;
      qos_prio = 3'h0;
      lut_map = 5'h0c;
      repeat (10) @(negedge clk_sys);
      reset = 1'b0;
      t_reset();
      t_entry();
      t_modes();
      t_count();
      t_ring();
      finish_test();
   end
endmodule
`default_nettype wire
